// file: logic/pdmau_pkg.sv
// constants and types shared by the peripheral dma channel block
package pdmau_pkg;
    // register word offsets inside one channel slot, slot stride and shift, global version address (byte addresses)
    localparam logic [11:0] OFS_MEM_PTR = 12'h000;
    localparam logic [11:0] OFS_PERIPH_SEL = 12'h004;
    localparam logic [11:0] OFS_REM_COUNT = 12'h008;
    localparam logic [11:0] OFS_PTR_RELOAD = 12'h00C;
    localparam logic [11:0] OFS_CNT_RELOAD = 12'h010;
    localparam logic [11:0] OFS_CMD = 12'h014;
    localparam logic [11:0] OFS_MODE = 12'h018;
    localparam logic [11:0] OFS_STATE = 12'h01C;
    localparam logic [11:0] OFS_IRQ_SET = 12'h020;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h024;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h028;
    localparam logic [11:0] OFS_IRQ_FLAGS = 12'h02C;
    localparam logic [11:0] CH_STRIDE = 12'h040;
    localparam logic [11:0] OFS_VERSION = 12'h3FC;
    localparam logic [5:0] CH_SHIFT = 6'h06;
    // command bits
    localparam int CMD_EN_BIT = 0;
    localparam int CMD_DIS_BIT = 1;
    localparam int CMD_ERROR_CLEAR_CMD_BIT = 8;
    // mode fields
    localparam int MODE_SIZE_LSB = 0;
    localparam int MODE_RING_BIT = 2;
    // irq flag bits
    localparam int IRQ_RCZ_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_FAULT_BIT = 2;
    // transfer sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // peripheral code ranges
    localparam logic [4:0] CODE_RX_LAST = 5'h0B;
    localparam logic [4:0] CODE_TX_LAST = 5'h15;
    localparam int CNT_W = 16;
    // arbitrary version value
    localparam logic [31:0] VERSION_VAL = 32'h00000100;
    typedef enum logic [2:0] {
        PDMAU_IDLE = 3'h1,
        PDMAU_RD = 3'h2,
        PDMAU_WR = 3'h4
    } pdmau_state_t;
endpackage

// file: logic/pdmau_top.sv
// multi-channel peripheral dma engine with register port
// What this block does
// [R1] pointer holds next memory address during transfer
// [R2] peripheral code picks handshake, direction, register
// [R3] count register reports items still to move
// [R4] pointer reloads when count zero, reload nonzero
// [R5] count reloads from reload register when zero
// [R6] zero reload at zero count stops transfers
// [R7] count reload clears reload register unless ring
// [R8] ring bit keeps reload registers after reload
// [R9] command register write-only, reset zero, at 0x014
// [R10] error clear restarts channel after fixing pointer
// [R11] disable command stops channel, clears enabled
// [R12] enable command starts channel; state shows enable
// [R13] irq set writes ones into mask
// [R14] irq clear writes ones out of mask
// [R15] fault flag sticky until error clear
// [R16] done flag while count and reload zero
// [R17] reload-empty flag while count reload zero
// [R18] codes 0-11 rx, 12-21 tx
// [R19] read-only version register, variant reserved
// [R20] pointer steps by size, count drops by one
// [R21] enabled channel starts on nonzero count write
// [R22] lower channel number served first
// [R23] bad access sets fault, stops channel, irq
// [R24] size codes byte, half, word are 0,1,2
// [R25] narrow peripheral reads zero-extended
`timescale 1ns/1ps
`default_nettype none
module pdmau_top
    import pdmau_pkg::*;
#(
    parameter int NCH = 7
) (
    input wire logic i_ref_clk, // 20 MHz clock
    input wire logic i_rst_n, // synchronous reset, low
    input wire logic [11:0] i_addr, // register byte address
    input wire logic [31:0] i_wdata, // register write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rdata, // read data, cycle after strobe
    input wire logic [NCH-1:0] i_periph_req, // peripheral requests
    output logic [4:0] o_periph_code, // code of active channel
    output logic o_periph_tx, // 1: memory to peripheral
    output logic o_periph_rd, // peripheral holding reg read
    output logic o_periph_wr, // peripheral holding reg write
    output logic [31:0] o_periph_wdata, // data to peripheral
    input wire logic [31:0] i_periph_rdata, // data from peripheral
    output logic [NCH-1:0] o_periph_ack, // transfer done pulse
    output logic o_mem_rd, // memory read strobe
    output logic o_mem_wr, // memory write strobe
    output logic [31:0] o_mem_addr, // memory address
    output logic [1:0] o_mem_size, // memory access size
    output logic [31:0] o_mem_wdata, // memory write data
    input wire logic [31:0] i_mem_rdata, // memory read data
    input wire logic i_mem_err, // bad address, with data
    output logic [NCH-1:0] o_irq // per channel interrupt
);
    localparam int CW = $clog2(NCH);

    logic [31:0] ptr_ff [NCH];
    logic [31:0] ptr_rl_ff [NCH];
    logic [CNT_W-1:0] cnt_ff [NCH];
    logic [CNT_W-1:0] cnt_rl_ff [NCH];
    logic [4:0] code_ff [NCH];
    logic [1:0] size_ff [NCH];
    logic [NCH-1:0] ring_ff;
    logic [NCH-1:0] en_ff;
    logic [NCH-1:0] fault_ff;
    logic [2:0] mask_ff [NCH];
    logic [NCH-1:0] req_s1_ff;
    logic [NCH-1:0] req_s2_ff;
    pdmau_state_t state_ff;
    logic [CW-1:0] cur_ff;

    function automatic logic [31:0] step_of(input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: step_of = 32'h00000001;
            SIZE_HALF: step_of = 32'h00000002;
            default: step_of = 32'h00000004; // [R24]
        endcase
    endfunction

    function automatic logic [31:0] zext(input logic [31:0] d,
                                         input logic [1:0] sz);
        case (sz)
            SIZE_BYTE: zext = {24'h000000, d[7:0]}; // [R25]
            SIZE_HALF: zext = {16'h0000, d[15:0]}; // [R25]
            default: zext = d;
        endcase
    endfunction

    function automatic logic is_tx(input logic [4:0] c);
        is_tx = (c > CODE_RX_LAST) && (c <= CODE_TX_LAST); // [R18]
    endfunction

    // register decode
    logic [CW-1:0] a_ch;
    logic [11:0] a_ofs;
    logic a_inch;
    assign a_ch = CW'(i_addr >> CH_SHIFT);
    assign a_ofs = i_addr & (CH_STRIDE - 12'h001);
    assign a_inch = (i_addr >> CH_SHIFT) < 12'(NCH);

    // requests pass two flip-flops
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            req_s1_ff <= '0;
            req_s2_ff <= '0;
        end else begin
            req_s1_ff <= i_periph_req;
            req_s2_ff <= req_s1_ff;
        end
    end

    // a channel can run while enabled, fault-free and with work
    logic [NCH-1:0] ready;
    logic any_ready;
    logic [CW-1:0] pick;
    always_comb begin
        any_ready = 1'b0;
        pick = '0;
        for (int k = NCH - 1; k >= 0; k--) begin
            ready[k] = en_ff[k] && !fault_ff[k] && req_s2_ff[k]
                       && (cnt_ff[k] != '0); // [R6] [R21]
            if (ready[k]) begin
                pick = CW'(k); // [R22]
                any_ready = 1'b1;
            end
        end
    end

    // transfer engine: read source, then write destination
    logic xfer_done;
    logic xfer_err;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            state_ff <= PDMAU_IDLE;
            cur_ff <= '0;
            o_periph_code <= '0;
            o_periph_tx <= 1'b0;
            o_periph_rd <= 1'b0;
            o_periph_wr <= 1'b0;
            o_periph_wdata <= '0;
            o_periph_ack <= '0;
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_mem_addr <= '0;
            o_mem_size <= '0;
            o_mem_wdata <= '0;
        end else begin
            o_periph_rd <= 1'b0;
            o_periph_wr <= 1'b0;
            o_mem_rd <= 1'b0;
            o_mem_wr <= 1'b0;
            o_periph_ack <= '0;
            case (state_ff)
                PDMAU_IDLE: begin
                    if (any_ready) begin
                        cur_ff <= pick;
                        o_periph_code <= code_ff[pick]; // [R2]
                        o_periph_tx <= is_tx(code_ff[pick]);
                        o_mem_addr <= ptr_ff[pick]; // [R1]
                        o_mem_size <= size_ff[pick];
                        o_mem_rd <= is_tx(code_ff[pick]);
                        o_periph_rd <= !is_tx(code_ff[pick]);
                        state_ff <= PDMAU_RD;
                    end
                end
                PDMAU_RD: begin
                    if (o_periph_tx) begin
                        o_periph_wdata <= i_mem_rdata;
                        o_periph_wr <= !i_mem_err;
                    end else begin
                        o_mem_wdata <= zext(i_periph_rdata,
                                            size_ff[cur_ff]);
                        o_mem_wr <= 1'b1;
                    end
                    state_ff <= o_periph_tx && i_mem_err ?
                                PDMAU_IDLE : PDMAU_WR;
                end
                PDMAU_WR: begin
                    o_periph_ack[cur_ff] <= !xfer_err;
                    state_ff <= PDMAU_IDLE;
                end
                default: state_ff <= PDMAU_IDLE;
            endcase
        end
    end
    assign xfer_done = (state_ff == PDMAU_WR) && !xfer_err;
    assign xfer_err = i_mem_err && ((state_ff == PDMAU_RD && o_periph_tx)
                      || (state_ff == PDMAU_WR && !o_periph_tx)); // [R23]

    // per channel registers
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic wsel;
        logic cmd_w;
        logic fin;
        logic rl_go;
        assign wsel = i_wr && a_inch && (a_ch == CW'(c));
        assign cmd_w = wsel && (a_ofs == OFS_CMD); // [R9]
        assign fin = xfer_done && (cur_ff == CW'(c));
        // reload when count hits zero or reload written at zero
        assign rl_go = (fin && cnt_ff[c] == CNT_W'(1)
                        && cnt_rl_ff[c] != '0)
                       || (cnt_ff[c] == '0 && cnt_rl_ff[c] != '0);

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                ptr_ff[c] <= '0;
                cnt_ff[c] <= '0;
            end else if (wsel && a_ofs == OFS_MEM_PTR) begin
                ptr_ff[c] <= i_wdata;
            end else if (wsel && a_ofs == OFS_REM_COUNT) begin
                cnt_ff[c] <= i_wdata[CNT_W-1:0]; // [R3]
            end else if (rl_go) begin
                ptr_ff[c] <= ptr_rl_ff[c]; // [R4]
                cnt_ff[c] <= cnt_rl_ff[c]; // [R5]
            end else if (fin) begin
                ptr_ff[c] <= ptr_ff[c] + step_of(size_ff[c]); // [R20]
                cnt_ff[c] <= cnt_ff[c] - CNT_W'(1); // [R20]
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                ptr_rl_ff[c] <= '0;
                cnt_rl_ff[c] <= '0;
            end else if (wsel && a_ofs == OFS_PTR_RELOAD) begin
                ptr_rl_ff[c] <= i_wdata;
            end else if (wsel && a_ofs == OFS_CNT_RELOAD) begin
                cnt_rl_ff[c] <= i_wdata[CNT_W-1:0];
            end else if (rl_go && !ring_ff[c]) begin
                ptr_rl_ff[c] <= '0; // [R7] [R8]
                cnt_rl_ff[c] <= '0; // [R7]
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                code_ff[c] <= '0;
                size_ff[c] <= SIZE_BYTE;
                ring_ff[c] <= 1'b0;
            end else if (wsel && a_ofs == OFS_PERIPH_SEL) begin
                code_ff[c] <= i_wdata[4:0]; // [R2]
            end else if (wsel && a_ofs == OFS_MODE) begin
                size_ff[c] <= i_wdata[MODE_SIZE_LSB +: 2];
                ring_ff[c] <= i_wdata[MODE_RING_BIT]; // [R8]
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                en_ff[c] <= 1'b0;
            end else if (cmd_w && i_wdata[CMD_DIS_BIT]) begin
                en_ff[c] <= 1'b0; // [R11]
            end else if (cmd_w && i_wdata[CMD_EN_BIT]) begin
                en_ff[c] <= 1'b1; // [R12]
            end
        end

        // error beats a clear in the same cycle
        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                fault_ff[c] <= 1'b0;
            end else if (xfer_err && cur_ff == CW'(c)) begin
                fault_ff[c] <= 1'b1; // [R15] [R23]
            end else if (cmd_w && i_wdata[CMD_ERROR_CLEAR_CMD_BIT]) begin
                fault_ff[c] <= 1'b0; // [R10]
            end
        end

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                mask_ff[c] <= '0;
            end else if (wsel && a_ofs == OFS_IRQ_SET) begin
                mask_ff[c] <= mask_ff[c] | i_wdata[2:0]; // [R13]
            end else if (wsel && a_ofs == OFS_IRQ_CLR) begin
                mask_ff[c] <= mask_ff[c] & ~i_wdata[2:0]; // [R14]
            end
        end

        logic [2:0] flags;
        always_comb begin
            flags = '0;
            flags[IRQ_RCZ_BIT] = cnt_rl_ff[c] == '0; // [R17]
            flags[IRQ_DONE_BIT] = cnt_ff[c] == '0
                                  && cnt_rl_ff[c] == '0; // [R16]
            flags[IRQ_FAULT_BIT] = fault_ff[c]; // [R15]
        end

        always_ff @(posedge i_ref_clk) begin
            if (!i_rst_n) begin
                o_irq[c] <= 1'b0;
            end else begin
                o_irq[c] <= |(flags & mask_ff[c]); // [R23]
            end
        end
    end

    // read data, one cycle after the strobe
    logic [31:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (i_addr == OFS_VERSION) begin
            rd_val = VERSION_VAL; // [R19]
        end else if (a_inch) begin
            case (a_ofs)
                OFS_MEM_PTR: rd_val = ptr_ff[a_ch]; // [R1]
                OFS_PERIPH_SEL: rd_val = {27'h0000000, code_ff[a_ch]};
                OFS_REM_COUNT: rd_val = 32'(cnt_ff[a_ch]); // [R3]
                OFS_PTR_RELOAD: rd_val = ptr_rl_ff[a_ch];
                OFS_CNT_RELOAD: rd_val = 32'(cnt_rl_ff[a_ch]);
                OFS_MODE: rd_val = {29'h00000000, ring_ff[a_ch],
                                    size_ff[a_ch]};
                OFS_STATE: rd_val = {31'h00000000, en_ff[a_ch]}; // [R12]
                OFS_IRQ_MASK: rd_val = {29'h00000000, mask_ff[a_ch]};
                OFS_IRQ_FLAGS: rd_val = {29'h00000000, fault_ff[a_ch],
                    cnt_ff[a_ch] == '0 && cnt_rl_ff[a_ch] == '0,
                    cnt_rl_ff[a_ch] == '0};
                default: rd_val = '0; // [R9]
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= i_rd ? rd_val : '0;
        end
    end
endmodule
`default_nettype wire

// file: test/pdmau_top_asserts.sv
// port assertions for the peripheral dma block
`timescale 1ns/1ps
`default_nettype none
module pdmau_top_asserts
    import pdmau_pkg::*;
#(
    parameter int NCH = 7
) (
    input wire logic i_ref_clk, // clock
    input wire logic i_rst_n, // reset, low
    input wire logic [11:0] i_addr, // register address
    input wire logic i_rd, // read strobe
    input wire logic [31:0] o_rdata, // read data
    input wire logic o_periph_tx, // direction
    input wire logic o_periph_rd, // holding read
    input wire logic o_periph_wr, // holding write
    input wire logic [NCH-1:0] o_periph_ack, // done pulses
    input wire logic o_mem_wr, // memory write
    input wire logic [1:0] o_mem_size, // access size
    input wire logic [31:0] o_mem_wdata, // memory data
    input wire logic i_mem_err // bad address
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    chk_version_read: assert property ($past(i_rd) &&
        $past(i_addr) == OFS_VERSION |-> o_rdata == VERSION_VAL)
        else $error("version bad");
    chk_cmd_wo: assert property ($past(i_rd) && $past(i_addr) ==
        OFS_CMD |-> o_rdata == 32'h0) else $error("command reads back");
    chk_rx_dir: assert property (o_periph_rd |-> !o_periph_tx)
        else $error("holding read on tx");
    chk_tx_dir: assert property (o_periph_wr |-> o_periph_tx)
        else $error("holding write on rx");
    chk_rx_order: assert property (o_periph_rd |=> o_mem_wr)
        else $error("no memory write after holding read");
    chk_byte_zext: assert property (o_mem_wr && o_mem_size ==
        SIZE_BYTE |-> o_mem_wdata[31:8] == 24'h0)
        else $error("byte not zeroed");
    chk_half_zext: assert property (o_mem_wr && o_mem_size ==
        SIZE_HALF |-> o_mem_wdata[31:16] == 16'h0)
        else $error("half not zeroed");
    chk_ack_onehot: assert property ($onehot0(o_periph_ack))
        else $error("two channels acked");
    // the memory answer is sampled at the edge that sees the strobe high
    chk_err_noack: assert property (o_mem_wr && i_mem_err |=>
        (o_periph_ack == '0) [*2]) else $error("ack after fault");
    chk_ok_ack: assert property (o_mem_wr && !i_mem_err |=>
        o_periph_ack != '0) else $error("missing ack");
endmodule
bind pdmau_top pdmau_top_asserts #(.NCH(NCH)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_periph_tx(o_periph_tx),
    .o_periph_rd(o_periph_rd), .o_periph_wr(o_periph_wr),
    .o_periph_ack(o_periph_ack), .o_mem_wr(o_mem_wr),
    .o_mem_size(o_mem_size), .o_mem_wdata(o_mem_wdata),
    .i_mem_err(i_mem_err));
`default_nettype wire

// file: test/pdmau_far.sv
// peripheral and memory model on the far side of the dma block
`timescale 1ns/1ps
`default_nettype none
module pdmau_far #(
    parameter int NCH = 7
) (
    input wire logic i_ref_clk, // clock
    input wire logic [NCH-1:0] i_req_en, // bench wants requests
    input wire logic [NCH-1:0] i_ack, // done pulses
    input wire logic i_prd, // holding read
    input wire logic i_pwr, // holding write
    input wire logic [31:0] i_pwdata, // data to peripheral
    input wire logic i_mrd, // memory read
    input wire logic i_mwr, // memory write
    input wire logic [31:0] i_pointer_value, // memory address
    input wire logic [31:0] i_mwdata, // memory write data
    output logic [NCH-1:0] o_req, // requests
    output logic [31:0] o_prdata, // holding data
    output logic [31:0] o_mrdata, // memory data
    output logic o_merr // bad address
);
    int gap [NCH];
    logic [31:0] seed = 32'h1357_9BDF;
    logic [31:0] ma_q[$], md_q[$], pw_q[$], mwa_q[$], mwd_q[$], pd_q[$];
    int ack_q[$];
    // data and error answer within the strobe's own cycle; the seed
    // moves every clock so stale values never match
    assign o_mrdata = seed;
    assign o_prdata = ~seed;
    assign o_merr = (i_mrd || i_mwr) && i_pointer_value[31:28] == 4'hF;
    initial begin
        o_req = '0;
        foreach (gap[n]) gap[n] = 0;
    end
    task automatic flush();
        ma_q.delete();
        md_q.delete();
        pw_q.delete();
        mwa_q.delete();
        mwd_q.delete();
        pd_q.delete();
        ack_q.delete();
    endtask
    always @(posedge i_ref_clk) begin
        seed <= {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        for (int n = 0; n < NCH; n++) begin
            // request drops after ack so the sync stages can drain
            if (i_ack[n]) begin
                gap[n] <= 3;
                ack_q.push_back(n);
            end else if (gap[n] > 0) begin
                gap[n] <= gap[n] - 1;
            end
            o_req[n] <= i_req_en[n] && !i_ack[n] && gap[n] == 0;
        end
        if (i_prd) pd_q.push_back(~seed);
        if (i_mrd) ma_q.push_back(i_pointer_value);
        if (i_mrd) md_q.push_back(seed);
        if (i_pwr) pw_q.push_back(i_pwdata);
        if (i_mwr) mwa_q.push_back(i_pointer_value);
        if (i_mwr) mwd_q.push_back(i_mwdata);
    end
endmodule
`default_nettype wire

// file: test/tb_pdmau_top.sv
// self-checking bench for the peripheral dma block
`timescale 1ns/1ps
`default_nettype none
module tb_pdmau_top;
    import pdmau_pkg::*;
    localparam int NCH = 7;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [NCH-1:0] req_en = '0;
    logic [NCH-1:0] req, ack, o_irq;
    logic [31:0] o_rdata, pwdata, prdata, pointer_value, mwdata, mrdata, v, p;
    logic prd, pwr, mrd, mwr, merr;
    logic [4:0] pcode;
    logic [1:0] msz;
    logic [31:0] rnd = 32'h6524_0D7B;
    int err_count = 0;
    int checked = 0;
    pdmau_top #(.NCH(NCH)) dut_u (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_periph_req(req), .o_periph_code(pcode), .o_periph_tx(),
        .o_periph_rd(prd), .o_periph_wr(pwr), .o_periph_wdata(pwdata),
        .i_periph_rdata(prdata), .o_periph_ack(ack), .o_mem_rd(mrd),
        .o_mem_wr(mwr), .o_mem_addr(pointer_value), .o_mem_size(msz),
        .o_mem_wdata(mwdata), .i_mem_rdata(mrdata), .i_mem_err(merr),
        .o_irq(o_irq));
    pdmau_far #(.NCH(NCH)) far_u (
        .i_ref_clk(i_ref_clk), .i_req_en(req_en), .i_ack(ack),
        .i_prd(prd), .i_pwr(pwr), .i_pwdata(pwdata), .i_mrd(mrd),
        .i_mwr(mwr), .i_pointer_value(pointer_value), .i_mwdata(mwdata), .o_req(req),
        .o_prdata(prdata), .o_mrdata(mrdata), .o_merr(merr));
    initial begin
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] msk(input int s);
        return (s == 0) ? 32'h0000_00FF : (s == 1) ? 32'h0000_FFFF : '1;
    endfunction
    task automatic test_done();
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input int ch, input logic [11:0] ofs,
                      input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= ofs + CH_STRIDE * ch[11:0];
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input string nm, input int ch, input logic [11:0] ofs,
                        input logic [31:0] exp);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= ofs + CH_STRIDE * ch[11:0];
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, o_rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic wait_ack(input int n);
        for (int i = 0; i < 400 && far_u.ack_q.size() < n; i++) begin
            @(posedge i_ref_clk);
        end
        if (far_u.ack_q.size() < n) begin
            err_count++;
            test_done();
        end
    endtask
    initial begin
        cyc(6);
        i_rst_n <= 1'b1;
        rchk("state", 0, OFS_STATE, 32'h0);
        rchk("flags", 0, OFS_IRQ_FLAGS, 32'h3);
        rchk("mask", 0, OFS_IRQ_MASK, 32'h0);
        rchk("cmd", 0, OFS_CMD, 32'h0);
        rchk("hole", 0, 12'h030, 32'h0);
        rchk("version", 0, OFS_VERSION, VERSION_VAL);
        wr(6, OFS_IRQ_SET, 32'h7);
        wr(6, OFS_IRQ_CLR, 32'h2);
        wr(6, OFS_IRQ_SET, 32'h0);
        rchk("mask", 6, OFS_IRQ_MASK, 32'h5);
        chk("irq", 32'(o_irq), 32'h40);
        wr(6, OFS_IRQ_CLR, 32'h7);
        cyc(2);
        chk("irq", 32'(o_irq), 32'h0);
        // receive channel through every transfer size
        wr(1, OFS_PERIPH_SEL, 32'h3);
        wr(1, OFS_CMD, 32'h1);
        rchk("state", 1, OFS_STATE, 32'h1);
        req_en[1] <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            rnd = lfsr(rnd);
            p = rnd & 32'h0FFF_FFF0;
            far_u.flush();
            wr(1, OFS_MODE, 32'(s));
            wr(1, OFS_MEM_PTR, p);
            wr(1, OFS_REM_COUNT, 32'h2);
            wait_ack(2);
            chk("size", 32'(msz), 32'(s));
            for (int k = 0; k < 2; k++) begin
                chk("waddr", far_u.mwa_q[k], p + 32'(k << s));
                chk("wdata", far_u.mwd_q[k], far_u.pd_q[k] & msk(s));
            end
            rchk("ptr", 1, OFS_MEM_PTR, p + 32'(2 << s));
            rchk("count", 1, OFS_REM_COUNT, 32'h0);
        end
        req_en[1] <= 1'b0;
        // transmit ring started by a reload write
        rnd = lfsr(rnd);
        p = rnd & 32'h0FFF_FFF0;
        far_u.flush();
        wr(0, OFS_PERIPH_SEL, 32'hC);
        wr(0, OFS_MODE, 32'h6);
        wr(0, OFS_CMD, 32'h1);
        wr(0, OFS_PTR_RELOAD, p);
        req_en[0] <= 1'b1;
        wr(0, OFS_CNT_RELOAD, 32'h2);
        wait_ack(4);
        wr(0, OFS_CMD, 32'h2);
        rchk("state", 0, OFS_STATE, 32'h0);
        rchk("reload", 0, OFS_CNT_RELOAD, 32'h2);
        for (int k = 0; k < 4; k++) begin
            chk("raddr", far_u.ma_q[k], p + 32'((k % 2) * 4));
            chk("pdata", far_u.pw_q[k], far_u.md_q[k]);
        end
        v = 32'(far_u.ack_q.size());
        cyc(30);
        chk("stopped", 32'(far_u.ack_q.size()), v);
        req_en[0] <= 1'b0;
        // single reload without ring, then the channel stays quiet
        far_u.flush();
        wr(2, OFS_PERIPH_SEL, 32'hD);
        wr(2, OFS_CMD, 32'h1);
        wr(2, OFS_MEM_PTR, 32'h0000_1000);
        wr(2, OFS_REM_COUNT, 32'h1);
        wr(2, OFS_PTR_RELOAD, 32'h0000_2000);
        wr(2, OFS_CNT_RELOAD, 32'h1);
        req_en[2] <= 1'b1;
        wait_ack(2);
        cyc(30);
        chk("acks", 32'(far_u.ack_q.size()), 32'h2);
        chk("addr0", far_u.ma_q[0], 32'h0000_1000);
        chk("addr1", far_u.ma_q[1], 32'h0000_2000);
        rchk("reload", 2, OFS_CNT_RELOAD, 32'h0);
        rchk("flags", 2, OFS_IRQ_FLAGS, 32'h3);
        req_en[2] <= 1'b0;
        // fault on a bad pointer, then recovery by error clear
        far_u.flush();
        wr(3, OFS_IRQ_SET, 32'h4);
        wr(3, OFS_PERIPH_SEL, 32'h5);
        wr(3, OFS_CMD, 32'h1);
        wr(3, OFS_MEM_PTR, 32'hF000_0000);
        wr(3, OFS_REM_COUNT, 32'h1);
        req_en[3] <= 1'b1;
        cyc(30);
        rchk("flags", 3, OFS_IRQ_FLAGS, 32'h5);
        rchk("count", 3, OFS_REM_COUNT, 32'h1);
        chk("irq", 32'(o_irq), 32'h8);
        chk("code", 32'(pcode), 32'h5);
        wr(3, OFS_MEM_PTR, 32'h0000_3000);
        wr(3, OFS_CMD, 32'h100);
        wait_ack(1);
        v = far_u.mwa_q[far_u.mwa_q.size() - 1];
        chk("addr", v, 32'h0000_3000);
        rchk("flags", 3, OFS_IRQ_FLAGS, 32'h3);
        req_en[3] <= 1'b0;
        // two channels asking together
        for (int c = 4; c < 6; c++) begin
            wr(c, OFS_PERIPH_SEL, 32'(c + 2));
            wr(c, OFS_CMD, 32'h1);
            wr(c, OFS_MEM_PTR, 32'h0000_4000);
            wr(c, OFS_REM_COUNT, 32'h1);
        end
        far_u.flush();
        req_en[5:4] <= 2'h3;
        wait_ack(2);
        chk("first", 32'(far_u.ack_q[0]), 32'h4);
        test_done();
    end
endmodule
`default_nettype wire
